/* File: rtl/tps_stop_regs.sv */
// Stop-reason flags and protection thresholds of the transmitter mode
`timescale 1ns/100ps
// Operation
// - Over-voltage stop sets bit 0 of the first stop-reason byte.
// - Over-current stop sets bit 1 of the first stop-reason byte.
// - Over-temperature stop sets bit 2 of the first stop-reason byte.
// - Missing received-power packet sets read-only bit 7 of the first byte.
// - Signal, identification or configuration packet at wrong time sets second byte bit 0.
// - Internal fault sets second byte bit 1; signal-strength timeout sets bit 2.
// - Bad signal-strength packet sets second byte bit 3.
// - Bad identification packet sets second byte bit 4.
// - Bad configuration packet sets second byte bit 5.
// - Optional packet count mismatch sets second byte bit 6.
// - Bad power-control hold-off packet sets second byte bit 7.
// - Bad extended identification packet sets writable third byte bit 0.
// - Failed negotiation sets third byte bit 1; negotiation timeout sets bit 2.
// - Writable 8-bit over-voltage threshold at 0x00DD, 500 mV per count.
// - Writable over-current threshold at 0x00DE, 100 mA per count.
// - Over-current threshold zero disables protection; one is the smallest level.
// - Writable temperature limit at 0x00DF in degrees; trips above it.
module tps_stop_regs (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Register port
	input wire logic [15:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// Transfer state and protocol events
	input wire logic transfer_active_in,
	input wire logic transfer_start_in,
	input tps_pkg::tps_evt_t evt_in,
	input tps_pkg::tps_meas_t meas_in,
	// Stop request
	output logic power_transfer_end_out
);

	logic [7:0] tx_overvoltage_threshold;
	logic [7:0] tx_overcurrent_threshold;
	logic [7:0] tx_overtemp_threshold;
	logic [7:0] stop_reason_0;
	logic [7:0] stop_reason_1;
	logic [7:0] stop_reason_2;
	logic [2:0] breach;
	logic [7:0] set_0;
	logic [7:0] set_1;
	logic [7:0] set_2;
	logic ended;
	logic any_set;

	// Register write decode, shared by every writable register
	function automatic logic wr_hit(input logic wr, input logic [15:0] addr, input logic [15:0] target);
		wr_hit = wr && (addr == target);
	endfunction

	tps_limit_cmp u_limit_cmp (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.meas_in(meas_in),
		.ovp_thr_in(tx_overvoltage_threshold),
		.ocp_thr_in(tx_overcurrent_threshold),
		.otp_thr_in(tx_overtemp_threshold),
		.breach_out(breach)
	);

	// Threshold registers
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			tx_overvoltage_threshold <= tps_pkg::RST_OVP_THR;
			tx_overcurrent_threshold <= tps_pkg::RST_OCP_THR;
			tx_overtemp_threshold <= tps_pkg::RST_OTP_THR;
		end else begin
			if (wr_hit(reg_wr_in, reg_addr_in, tps_pkg::ADDR_OVP_THR)) begin
				tx_overvoltage_threshold <= reg_wdata_in;
			end
			if (wr_hit(reg_wr_in, reg_addr_in, tps_pkg::ADDR_OCP_THR)) begin
				tx_overcurrent_threshold <= reg_wdata_in;
			end
			if (wr_hit(reg_wr_in, reg_addr_in, tps_pkg::ADDR_OTP_THR)) begin
				tx_overtemp_threshold <= reg_wdata_in;
			end
		end
	end

	// Causes are only recorded while power is flowing, so idle noise cannot fake a reason
	always_comb begin
		set_0 = 8'h00;
		set_1 = 8'h00;
		set_2 = 8'h00;
		if (transfer_active_in) begin
			set_0[tps_pkg::SR0_OVP] = breach[tps_pkg::BR_OVP];
			set_0[tps_pkg::SR0_OCP] = breach[tps_pkg::BR_OCP];
			set_0[tps_pkg::SR0_OTP] = breach[tps_pkg::BR_OTP];
			set_0[tps_pkg::SR0_RX_POWER_TO] = evt_in.rx_power_packet_timeout_flag;
			set_1[tps_pkg::SR1_RX_RESTART] = evt_in.rx_restart;
			set_1[tps_pkg::SR1_INTERNAL_FAULT] = evt_in.internal_fault_flag;
			set_1[tps_pkg::SR1_STRENGTH_TO] = evt_in.strength_packet_timeout_flag;
			set_1[tps_pkg::SR1_STRENGTH_ERR] = evt_in.strength_packet_error;
			set_1[tps_pkg::SR1_IDENT_ERR] = evt_in.ident_packet_error_flag;
			set_1[tps_pkg::SR1_CONFIG_ERR] = evt_in.config_packet_error;
			set_1[tps_pkg::SR1_OPT_COUNT] = evt_in.optional_count_mismatch_flag;
			set_1[tps_pkg::SR1_HOLDOFF_ERR] = evt_in.holdoff_packet_error_flag;
			set_2[tps_pkg::SR2_EXT_IDENT_ERR] = evt_in.ext_ident_error_flag;
			set_2[tps_pkg::SR2_NEG_FAIL] = evt_in.negotiation_fail_flag;
			set_2[tps_pkg::SR2_NEG_TO] = evt_in.negotiation_timeout_flag;
		end
	end

	assign any_set = |{set_0, set_1, set_2};

	// Read-only flags: cleared by a new transfer, a same-cycle event still wins
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			stop_reason_0 <= tps_pkg::RST_STOP_REASON;
			stop_reason_1 <= tps_pkg::RST_STOP_REASON;
		end else begin
			stop_reason_0 <= (transfer_start_in ? tps_pkg::RST_STOP_REASON : stop_reason_0) | set_0;
			stop_reason_1 <= (transfer_start_in ? tps_pkg::RST_STOP_REASON : stop_reason_1) | set_1;
		end
	end

	// Writable flag byte: software may clear or set bits 2:0, hardware set still wins
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			stop_reason_2 <= tps_pkg::RST_STOP_REASON;
		end else if (wr_hit(reg_wr_in, reg_addr_in, tps_pkg::ADDR_STOP_REASON_2)) begin
			stop_reason_2 <= (reg_wdata_in & tps_pkg::SR2_WRITE_MASK) | set_2;
		end else begin
			stop_reason_2 <= (transfer_start_in ? tps_pkg::RST_STOP_REASON : stop_reason_2) | set_2;
		end
	end

	// One end request per transfer: later causes are still logged but not re-requested
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			ended <= 1'b0;
			power_transfer_end_out <= 1'b0;
		end else begin
			power_transfer_end_out <= any_set && !ended && !transfer_start_in;
			if (transfer_start_in) begin
				ended <= 1'b0;
			end else if (any_set) begin
				ended <= 1'b1;
			end
		end
	end

	// Read data is registered; unmapped addresses read as zero
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= tps_pkg::UNMAPPED_READ;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				tps_pkg::ADDR_OVP_THR: reg_rdata_out <= tx_overvoltage_threshold;
				tps_pkg::ADDR_OCP_THR: reg_rdata_out <= tx_overcurrent_threshold;
				tps_pkg::ADDR_OTP_THR: reg_rdata_out <= tx_overtemp_threshold;
				tps_pkg::ADDR_STOP_REASON_0: reg_rdata_out <= stop_reason_0;
				tps_pkg::ADDR_STOP_REASON_1: reg_rdata_out <= stop_reason_1;
				tps_pkg::ADDR_STOP_REASON_2: reg_rdata_out <= stop_reason_2;
				default: reg_rdata_out <= tps_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// Steps of a protection stop: breach seen while active, then flag and end request
	sequence s_breach(int idx);
		transfer_active_in && breach[idx] && !ended && !transfer_start_in;
	endsequence

	sequence s_flag_and_end(int bit_pos);
		stop_reason_0[bit_pos] && power_transfer_end_out;
	endsequence

	chk_ovp_stop_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		s_breach(tps_pkg::BR_OVP) |=> s_flag_and_end(tps_pkg::SR0_OVP))
		else $error("over-voltage stop not recorded");

	chk_ocp_stop_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		s_breach(tps_pkg::BR_OCP) |=> s_flag_and_end(tps_pkg::SR0_OCP))
		else $error("over-current stop not recorded");

	chk_otp_stop_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		s_breach(tps_pkg::BR_OTP) |=> s_flag_and_end(tps_pkg::SR0_OTP))
		else $error("over-temperature stop not recorded");

	chk_rx_power_timeout: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		transfer_active_in && evt_in.rx_power_packet_timeout_flag |=> stop_reason_0[tps_pkg::SR0_RX_POWER_TO])
		else $error("received-power timeout not recorded");

	chk_byte1_events: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		transfer_active_in |=> (stop_reason_1 & $past(set_1)) == $past(set_1))
		else $error("protocol error not recorded in second byte");

	chk_negotiation_flags: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		transfer_active_in && (evt_in.negotiation_fail_flag || evt_in.negotiation_timeout_flag) |=>
		stop_reason_2[tps_pkg::SR2_NEG_FAIL] || stop_reason_2[tps_pkg::SR2_NEG_TO])
		else $error("negotiation error not recorded");

	chk_ext_ident_set_wins: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		transfer_active_in && evt_in.ext_ident_error_flag && reg_wr_in |=> stop_reason_2[tps_pkg::SR2_EXT_IDENT_ERR])
		else $error("extended identification error lost to a write");

	chk_ovp_thr_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		reg_wr_in && reg_addr_in == tps_pkg::ADDR_OVP_THR |=> tx_overvoltage_threshold == $past(reg_wdata_in))
		else $error("over-voltage threshold write lost");

	chk_ocp_thr_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		reg_wr_in && reg_addr_in == tps_pkg::ADDR_OCP_THR |=> tx_overcurrent_threshold == $past(reg_wdata_in))
		else $error("over-current threshold write lost");

	chk_flags_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		stop_reason_0 != 8'h00 && !transfer_start_in |=> (stop_reason_0 & $past(stop_reason_0)) == $past(stop_reason_0))
		else $error("stop reason lost without a new transfer");

	chk_single_end: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		power_transfer_end_out |=> !power_transfer_end_out)
		else $error("end request repeated within one transfer");

endmodule // tps_stop_regs

/* File: common/tps_pkg.sv */
// Package with register map, field layout and reset values of the stop-reason block
package tps_pkg;

	// Register offsets on the serial register port
	localparam logic [15:0] ADDR_OVP_THR = 16'h00dd;
	localparam logic [15:0] ADDR_OCP_THR = 16'h00de;
	localparam logic [15:0] ADDR_OTP_THR = 16'h00df;
	localparam logic [15:0] ADDR_STOP_REASON_0 = 16'h00f0;
	localparam logic [15:0] ADDR_STOP_REASON_1 = 16'h00f1;
	localparam logic [15:0] ADDR_STOP_REASON_2 = 16'h00f2;

	// Reset values of thresholds, flag bytes and read data
	localparam logic [7:0] RST_OVP_THR = 8'h28;
	localparam logic [7:0] RST_OCP_THR = 8'h0f;
	localparam logic [7:0] RST_OTP_THR = 8'h50;
	localparam logic [7:0] RST_STOP_REASON = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Threshold scaling: millivolts and milliamps per count
	localparam logic [8:0] OVP_MV_PER_COUNT = 9'h1f4;
	localparam logic [8:0] OCP_MA_PER_COUNT = 9'h064;
	localparam logic [7:0] OCP_DISABLED = 8'h00;

	// Breach vector positions
	localparam int BR_OVP = 0;
	localparam int BR_OCP = 1;
	localparam int BR_OTP = 2;

	// First stop-reason byte
	localparam int SR0_OVP = 0;
	localparam int SR0_OCP = 1;
	localparam int SR0_OTP = 2;
	localparam int SR0_RX_POWER_TO = 7;

	// Second stop-reason byte
	localparam int SR1_RX_RESTART = 0;
	localparam int SR1_INTERNAL_FAULT = 1;
	localparam int SR1_STRENGTH_TO = 2;
	localparam int SR1_STRENGTH_ERR = 3;
	localparam int SR1_IDENT_ERR = 4;
	localparam int SR1_CONFIG_ERR = 5;
	localparam int SR1_OPT_COUNT = 6;
	localparam int SR1_HOLDOFF_ERR = 7;

	// Third stop-reason byte, software writable bits
	localparam int SR2_EXT_IDENT_ERR = 0;
	localparam int SR2_NEG_FAIL = 1;
	localparam int SR2_NEG_TO = 2;
	localparam logic [7:0] SR2_WRITE_MASK = 8'h07;

	// Protocol events reported by the packet engine, one-cycle pulses
	typedef struct packed {
		logic rx_power_packet_timeout_flag;
		logic rx_restart;
		logic internal_fault_flag;
		logic strength_packet_timeout_flag;
		logic strength_packet_error;
		logic ident_packet_error_flag;
		logic config_packet_error;
		logic optional_count_mismatch_flag;
		logic holdoff_packet_error_flag;
		logic ext_ident_error_flag;
		logic negotiation_fail_flag;
		logic negotiation_timeout_flag;
	} tps_evt_t;

	// Measurements from the converter, same clock domain
	typedef struct packed {
		logic [15:0] voltage_mv;
		logic [15:0] current_ma;
		logic [7:0] temp_c;
	} tps_meas_t;

endpackage

/* File: rtl/tps_limit_cmp.sv */
// Threshold comparator for voltage, current and die temperature
`timescale 1ns/100ps
module tps_limit_cmp (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Measurements and thresholds
	input tps_pkg::tps_meas_t meas_in,
	input wire logic [7:0] ovp_thr_in,
	input wire logic [7:0] ocp_thr_in,
	input wire logic [7:0] otp_thr_in,
	// Registered breach vector
	output logic [2:0] breach_out
);

	// Threshold count times unit size; 255 counts still fit in 17 bits
	function automatic logic [16:0] scale(input logic [7:0] thr, input logic [8:0] unit);
		scale = 17'(thr) * 17'(unit); // Widen before the product so the top bits are kept
	endfunction

	// Compare every cycle; a registered result keeps the wide compare off the flag path
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			breach_out <= 3'h0;
		end else begin
			breach_out[tps_pkg::BR_OVP] <= {1'b0, meas_in.voltage_mv} >
				scale(ovp_thr_in, tps_pkg::OVP_MV_PER_COUNT);
			breach_out[tps_pkg::BR_OCP] <= (ocp_thr_in != tps_pkg::OCP_DISABLED) &&
				({1'b0, meas_in.current_ma} > scale(ocp_thr_in, tps_pkg::OCP_MA_PER_COUNT));
			breach_out[tps_pkg::BR_OTP] <= meas_in.temp_c > otp_thr_in;
		end
	end

	chk_ocp_zero_off: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ocp_thr_in == tps_pkg::OCP_DISABLED |=> !breach_out[tps_pkg::BR_OCP])
		else $error("current breach while protection disabled");

	chk_otp_trip_level: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		meas_in.temp_c > otp_thr_in |=> breach_out[tps_pkg::BR_OTP])
		else $error("temperature above limit not flagged");

	chk_ocp_one_count: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ocp_thr_in == 8'h01 && meas_in.current_ma == 16'h0065 |=> breach_out[tps_pkg::BR_OCP])
		else $error("smallest current trip level not honoured");

endmodule // tps_limit_cmp

/* File: testbench/tb_top.sv */
// Self-checking bench for the stop-reason flags and protection thresholds
`timescale 1ns/100ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin errors++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [15:0] reg_addr_in = 16'h0000;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [7:0] reg_rdata_out;
	logic transfer_active_in = 1'b0;
	logic transfer_start_in = 1'b0;
	tps_pkg::tps_evt_t evt_in = '0;
	tps_pkg::tps_meas_t meas_in = '0;
	logic power_transfer_end_out;
	int errors = 0;
	int checked = 0;
	int ends = 0;
	// Event order matches the packed struct, first field is the top bit
	logic [7:0] ev_addr [12] = '{8'hf0, 8'hf1, 8'hf1, 8'hf1, 8'hf1, 8'hf1, 8'hf1, 8'hf1, 8'hf1, 8'hf2, 8'hf2, 8'hf2};
	logic [7:0] ev_mask [12] = '{8'h80, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h01, 8'h02, 8'h04};

	// 250 MHz clock
	always #2 ref_clk_in = ~ref_clk_in;

	tps_stop_regs dut (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.reg_addr_in(reg_addr_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out),
		.transfer_active_in(transfer_active_in),
		.transfer_start_in(transfer_start_in),
		.evt_in(evt_in),
		.meas_in(meas_in),
		.power_transfer_end_out(power_transfer_end_out)
	);

	// Count end requests; a pulse that lasts two cycles counts twice and shows up
	always @(posedge ref_clk_in) begin
		if (power_transfer_end_out === 1'b1) ends++;
	end

	task automatic end_of_test();
		if (errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge ref_clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(negedge ref_clk_in);
		reg_wr_in = 1'b0;
	endtask

	// Read strobe for one edge, data sampled a full half period after it lands
	task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge ref_clk_in);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		@(negedge ref_clk_in);
		reg_rd_in = 1'b0;
		`CHK(reg_rdata_out, e)
	endtask

	// New transfer: start pulse clears flags, then active stays high
	task automatic new_transfer();
		@(negedge ref_clk_in);
		transfer_start_in = 1'b1;
		transfer_active_in = 1'b1;
		@(negedge ref_clk_in);
		transfer_start_in = 1'b0;
		ends = 0;
	endtask

	task automatic t_reset_values();
		chk_rd(16'h00dd, 8'h28);
		chk_rd(16'h00de, 8'h0f);
		chk_rd(16'h00df, 8'h50);
		chk_rd(16'h00f0, 8'h00);
		chk_rd(16'h00e0, 8'h00);
		wr(16'h00dd, 8'ha5);
		chk_rd(16'h00dd, 8'ha5);
		wr(16'h00de, 8'h5a);
		chk_rd(16'h00de, 8'h5a);
		wr(16'h00df, 8'h3c);
		chk_rd(16'h00df, 8'h3c);
		wr(16'h00e0, 8'hff);
		chk_rd(16'h00e0, 8'h00);
	endtask

	// Hold a level at the limit (no trip), then one cycle just above it
	task automatic t_prot(input logic [15:0] a, input logic [7:0] thr, input tps_pkg::tps_meas_t at_lim,
			input tps_pkg::tps_meas_t over, input logic [7:0] bitmask);
		new_transfer();
		wr(a, thr);
		meas_in = at_lim;
		repeat (6) @(negedge ref_clk_in);
		meas_in = '0;
		chk_rd(16'h00f0, 8'h00);
		`CHK(ends, 0)
		meas_in = over;
		@(negedge ref_clk_in);
		meas_in = '0;
		repeat (4) @(negedge ref_clk_in);
		chk_rd(16'h00f0, bitmask);
		`CHK(ends, 1)
	endtask

	task automatic t_ocp_disable();
		new_transfer();
		wr(16'h00de, 8'h00);
		meas_in = '{16'h0000, 16'hffff, 8'h00};
		repeat (6) @(negedge ref_clk_in);
		meas_in = '0;
		chk_rd(16'h00f0, 8'h00);
		`CHK(ends, 0)
	endtask

	// Every protocol cause lands on its own bit and requests the end once
	task automatic t_events();
		for (int i = 0; i < 12; i++) begin
			new_transfer();
			@(negedge ref_clk_in);
			evt_in = tps_pkg::tps_evt_t'(12'h800 >> i);
			@(negedge ref_clk_in);
			evt_in = '0;
			repeat (3) @(negedge ref_clk_in);
			chk_rd({8'h00, ev_addr[i]}, ev_mask[i]);
			`CHK(ends, 1)
		end
	endtask

	// Flags persist after the end, second cause logged without a second end
	task automatic t_hold_clear();
		@(negedge ref_clk_in);
		evt_in = tps_pkg::tps_evt_t'(12'h001);
		@(negedge ref_clk_in);
		evt_in = tps_pkg::tps_evt_t'(12'h008);
		@(negedge ref_clk_in);
		evt_in = '0;
		repeat (10) @(negedge ref_clk_in);
		chk_rd(16'h00f1, 8'h80);
		`CHK(ends, 1)
		wr(16'h00f1, 8'h00);
		chk_rd(16'h00f1, 8'h80);
		wr(16'h00f0, 8'hff);
		chk_rd(16'h00f0, 8'h00);
		chk_rd(16'h00f2, 8'h04);
		wr(16'h00f2, 8'h00);
		chk_rd(16'h00f2, 8'h00);
		wr(16'h00f2, 8'hff);
		chk_rd(16'h00f2, 8'h07);
		// Hardware set beats a software clear landing in the same cycle
		@(negedge ref_clk_in);
		reg_addr_in = 16'h00f2;
		reg_wdata_in = 8'h00;
		reg_wr_in = 1'b1;
		evt_in = tps_pkg::tps_evt_t'(12'h004);
		@(negedge ref_clk_in);
		reg_wr_in = 1'b0;
		evt_in = '0;
		chk_rd(16'h00f2, 8'h01);
		new_transfer();
		chk_rd(16'h00f1, 8'h00);
		chk_rd(16'h00f2, 8'h00);
		// Causes arriving while idle are not recorded and request no end
		@(negedge ref_clk_in);
		transfer_active_in = 1'b0;
		evt_in = tps_pkg::tps_evt_t'(12'h100);
		@(negedge ref_clk_in);
		evt_in = '0;
		repeat (3) @(negedge ref_clk_in);
		chk_rd(16'h00f1, 8'h00);
		`CHK(ends, 0)
	endtask

	// Watchdog sized well beyond the few hundred cycles the tests need
	initial begin
		#80000;
		errors++;
		end_of_test();
	end

	initial begin
		repeat (16) @(negedge ref_clk_in);
		rst_in = 1'b0;
		t_reset_values();
		t_prot(16'h00dd, 8'h10, '{16'h1f40, 16'h0000, 8'h00}, '{16'h1f41, 16'h0000, 8'h00}, 8'h01);
		t_prot(16'h00de, 8'h01, '{16'h0000, 16'h0064, 8'h00}, '{16'h0000, 16'h0065, 8'h00}, 8'h02);
		t_prot(16'h00df, 8'h50, '{16'h0000, 16'h0000, 8'h50}, '{16'h0000, 16'h0000, 8'h51}, 8'h04);
		t_ocp_disable();
		t_events();
		t_hold_clear();
		end_of_test();
	end
endmodule // tb_top
